// file: design/mpcm_pkg.sv
// Package for the multi-panel code memory erase and write sequencer.
// Assumes a 22-bit table address space, 8 panels and 8-byte write buffers.
package mpcm_pkg;
   // ---------------------------------------------------------------
   // Serial instruction format
   // ---------------------------------------------------------------
   localparam int INSTR_BITS = 20;
   localparam int CMD_BITS = 4;
   localparam logic [4:0] LAST_BIT = 5'h13;
   localparam logic [4:0] PULSE_BIT = 5'h03;
   // ---------------------------------------------------------------
   // Four-bit commands
   // ---------------------------------------------------------------
   localparam logic [3:0] CMD_CORE = 4'h0;
   localparam logic [3:0] CMD_TWR = 4'hC;
   localparam logic [3:0] CMD_TWR_INC2 = 4'hD;
   localparam logic [3:0] CMD_TWR_START = 4'hF;
   // ---------------------------------------------------------------
   // Core instruction opcodes (upper byte of operand; upper nibble for bit set and clear)
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_LOAD_LITERAL = 8'h0E;
   localparam logic [7:0] OP_STORE_WORKING = 8'h6E;
   localparam logic [7:0] OP_REGISTER_CLEAR = 8'h6A;
   localparam logic [3:0] OP_BIT_SET = 4'h8;
   localparam logic [3:0] OP_BIT_CLEAR = 4'h9;
   // ---------------------------------------------------------------
   // File register addresses seen by core instructions
   // ---------------------------------------------------------------
   localparam logic [7:0] FREG_ADDR_UPPER = 8'hF8;
   localparam logic [7:0] FREG_ADDR_HIGH = 8'hF7;
   localparam logic [7:0] FREG_ADDR_LOW = 8'hF6;
   localparam logic [7:0] FREG_NVM_CONTROL = 8'hA6;
   // ---------------------------------------------------------------
   // Memory control register bit positions
   // ---------------------------------------------------------------
   localparam int NVM_CODE_SEL_BIT = 7;
   localparam int NVM_CFG_SEL_BIT = 6;
   localparam int NVM_ROW_ERASE_BIT = 4;
   localparam int NVM_WRITE_ALLOW_BIT = 2;
   localparam logic [7:0] NVM_CONTROL_RESET = 8'h00;
   // ---------------------------------------------------------------
   // Programming control register
   // ---------------------------------------------------------------
   localparam logic [21:0] PROGRAMMING_CONTROL_ADDR = 22'h3C_0006;
   localparam logic [7:0] PROGRAMMING_CONTROL_RESET = 8'h00;
   localparam logic [7:0] MULTI_PANEL_VALUE = 8'h40;
   // ---------------------------------------------------------------
   // Table address fields
   // ---------------------------------------------------------------
   localparam int PANELS = 8;
   localparam int PANEL_LSB = 13;
   localparam int ROW_LSB = 6;
   localparam int CHUNK_LSB = 3;
   localparam logic [21:0] ADDR_RESET = 22'h00_0000;
   localparam logic [21:0] ADDR_STEP = 22'h00_0002;
   // ---------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------
   typedef enum logic {
      MPCM_IDLE = 1'b0,
      MPCM_PULSE = 1'b1
   } mpcm_state_t;
endpackage

// file: design/mpcm_buffer_mem.sv
// Write buffers of all panels, 32 words of 16 bits (low byte at even address).
// Assumes one write and one read per cycle; read data is registered.
`timescale 1ns/100ps
`default_nettype none
module mpcm_buffer_mem (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [4:0] wr_idx_i,
   input wire logic [15:0] wr_data_i,
   // Read port
   input wire logic [4:0] rd_idx_i,
   output logic [15:0] rd_data_o
);
   logic [15:0] mem [32];
   logic [15:0] next_rd_data;

   // Read data for the next edge
   always_comb begin
      next_rd_data = mem[rd_idx_i];
   end

   // Read register, cleared by reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= 16'h0000;
      end else if (ce_i) begin
         rd_data_o <= next_rd_data;
      end
   end

   // Array itself carries no reset
   always_ff @(posedge clk_i) begin
      if (ce_i && wr_en_i) begin
         mem[wr_idx_i] <= wr_data_i;
      end
   end
endmodule
`default_nettype wire

// file: design/mpcm_sequencer.sv
// Sequencer that takes serial instructions from an external programmer and
// loads panel write buffers, the table pointer and control registers, then
// raises an externally timed erase or write pulse toward the flash array.
// Assumes the programmer clock is a clock of its own, unrelated to clk_i.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Data taken on falling clock edge, LSB first
// - Twenty bits: four-bit command, sixteen-bit operand
// - Table pointer has upper, high, low parts
// - Erase one 64-byte row in every panel
// - Same row offset in each panel
// - Value 40h at 3C0006h enables multi-panel
// - Set code, config and write-allow bits first
// - Clear config select after setup write
// - Core instructions load the pointer bytes
// - Row-erase bit, start command, then a no-op
// - Erase lasts while fourth clock held high
// - Falling clock ends pulse; programmer waits discharge
// - Eight-byte buffer per panel, loaded before write
// - Multi-panel write programs all buffers together
// - 1101 stores bytes, adds two; 1100 only stores
// - Last load uses start command, then timed no-op
// - Write lasts while fourth clock held high
module mpcm_sequencer (
   // System clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Serial programming link
   input wire logic prog_serial_clock_i,
   input wire logic prog_serial_line_i,
   output logic prog_serial_line_o,
   output logic prog_serial_line_oe_o,
   // Flash array side
   output logic array_erase_o,
   output logic array_write_o,
   output logic [7:0] array_panel_mask_o,
   output logic [9:0] array_offset_o,
   input wire logic [4:0] array_rd_idx_i,
   output logic [15:0] array_rd_data_o,
   // Register state for observation
   output logic [21:0] table_address_pointer_o,
   output logic [7:0] programming_control_o,
   output logic [7:0] nvm_control_reg_o
);
   // ---------------------------------------------------------------
   // Link domain: shift register on the falling programmer clock
   // ---------------------------------------------------------------
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [19:0] shift, next_shift;
   logic [19:0] word, next_word;
   logic word_tog, next_word_tog;
   logic armed, next_armed;
   logic window, next_window;

   // Next link values: count bits, capture word, arm the timed pulse
   always_comb begin
      next_shift = {prog_serial_line_i, shift[19:1]};
      next_bit_cnt = bit_cnt + 5'h01;
      next_word = word;
      next_word_tog = word_tog;
      next_armed = armed;
      if (bit_cnt == mpcm_pkg::LAST_BIT) begin
         next_bit_cnt = 5'h00;
         next_word = next_shift;
         next_word_tog = ~word_tog;
         next_armed = (next_shift[3:0] == mpcm_pkg::CMD_TWR_START);
      end else if (bit_cnt == mpcm_pkg::PULSE_BIT) begin
         next_armed = 1'b0;
      end
      next_window = armed && (next_bit_cnt == mpcm_pkg::PULSE_BIT);
   end

   // Link registers
   always_ff @(negedge prog_serial_clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt <= 5'h00;
         shift <= 20'h0_0000;
         word <= 20'h0_0000;
         word_tog <= 1'b0;
         armed <= 1'b0;
         window <= 1'b0;
      end else begin
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         word <= next_word;
         word_tog <= next_word_tog;
         armed <= next_armed;
         window <= next_window;
      end
   end

   // ---------------------------------------------------------------
   // Crossing into the system clock domain
   // ---------------------------------------------------------------
   logic [2:0] tog_sync, next_tog_sync;
   logic [1:0] win_sync, next_win_sync;
   logic [1:0] sclk_sync, next_sclk_sync;
   logic word_take;

   // Two-stage synchronisers, third tog stage only for edge detection
   always_comb begin
      next_tog_sync = {tog_sync[1:0], word_tog};
      next_win_sync = {win_sync[0], window};
      next_sclk_sync = {sclk_sync[0], prog_serial_clock_i};
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tog_sync <= 3'h0;
         win_sync <= 2'h0;
         sclk_sync <= 2'h0;
      end else if (ce_i) begin
         tog_sync <= next_tog_sync;
         win_sync <= next_win_sync;
         sclk_sync <= next_sclk_sync;
      end
   end

   assign word_take = ce_i && (tog_sync[2] != tog_sync[1]);

   // ---------------------------------------------------------------
   // Command decode and register file
   // ---------------------------------------------------------------
   mpcm_pkg::mpcm_state_t state, next_state;
   logic [7:0] working, next_working;
   logic [21:0] tbl_ptr, next_tbl_ptr;
   logic [7:0] nvm_ctrl, next_nvm_ctrl;
   logic [7:0] prog_ctrl, next_prog_ctrl;
   logic erase_q, next_erase_q;
   logic write_q, next_write_q;
   logic [7:0] mask_q, next_mask_q;
   logic [9:0] offset_q, next_offset_q;
   logic mem_we;
   logic [4:0] mem_idx;
   logic [3:0] cmd;
   logic [7:0] op_hi, op_lo;
   logic multi;

   assign cmd = word[3:0];
   assign op_hi = word[19:12];
   assign op_lo = word[11:4];
   assign multi = (prog_ctrl == mpcm_pkg::MULTI_PANEL_VALUE);

   // True for any of the three table write commands
   function automatic logic is_table_write(input logic [3:0] c);
      is_table_write = (c == mpcm_pkg::CMD_TWR) || (c == mpcm_pkg::CMD_TWR_INC2) ||
         (c == mpcm_pkg::CMD_TWR_START);
   endfunction

   // Next pointer byte after a core store or clear
   function automatic logic [21:0] put_ptr(input logic [21:0] p, input logic [7:0] f,
                                           input logic [7:0] v);
      put_ptr = p;
      if (f == mpcm_pkg::FREG_ADDR_UPPER) put_ptr[21:16] = v[5:0];
      if (f == mpcm_pkg::FREG_ADDR_HIGH) put_ptr[15:8] = v;
      if (f == mpcm_pkg::FREG_ADDR_LOW) put_ptr[7:0] = v;
   endfunction

   // Buffer word address and write enable
   always_comb begin
      mem_idx = {tbl_ptr[mpcm_pkg::PANEL_LSB +: 3], tbl_ptr[2:1]};
      mem_we = word_take && (state == mpcm_pkg::MPCM_IDLE) && is_table_write(cmd) &&
         !nvm_ctrl[mpcm_pkg::NVM_CFG_SEL_BIT];
   end

   // Next values for decode and pulse control
   always_comb begin
      next_state = state;
      next_working = working;
      next_tbl_ptr = tbl_ptr;
      next_nvm_ctrl = nvm_ctrl;
      next_prog_ctrl = prog_ctrl;
      next_erase_q = erase_q;
      next_write_q = write_q;
      next_mask_q = mask_q;
      next_offset_q = offset_q;
      case (state)
         mpcm_pkg::MPCM_IDLE: begin
            if (word_take && cmd == mpcm_pkg::CMD_CORE) begin
               if (op_hi == mpcm_pkg::OP_LOAD_LITERAL) begin
                  next_working = op_lo;
               end else if (op_hi == mpcm_pkg::OP_STORE_WORKING) begin
                  next_tbl_ptr = put_ptr(tbl_ptr, op_lo, working);
               end else if (op_hi == mpcm_pkg::OP_REGISTER_CLEAR) begin
                  next_tbl_ptr = put_ptr(tbl_ptr, op_lo, 8'h00);
               end else if (op_lo == mpcm_pkg::FREG_NVM_CONTROL &&
                            op_hi[7:4] == mpcm_pkg::OP_BIT_SET) begin
                  next_nvm_ctrl[op_hi[3:1]] = 1'b1;
               end else if (op_lo == mpcm_pkg::FREG_NVM_CONTROL &&
                            op_hi[7:4] == mpcm_pkg::OP_BIT_CLEAR) begin
                  next_nvm_ctrl[op_hi[3:1]] = 1'b0;
               end
            end else if (word_take && is_table_write(cmd)) begin
               if (nvm_ctrl[mpcm_pkg::NVM_CFG_SEL_BIT] &&
                   tbl_ptr == mpcm_pkg::PROGRAMMING_CONTROL_ADDR) begin
                  next_prog_ctrl = op_lo;
               end
               if (cmd == mpcm_pkg::CMD_TWR_INC2) begin
                  next_tbl_ptr = tbl_ptr + mpcm_pkg::ADDR_STEP;
               end
            end
            if (win_sync[1] && sclk_sync[1] && nvm_ctrl[mpcm_pkg::NVM_WRITE_ALLOW_BIT]) begin
               next_state = mpcm_pkg::MPCM_PULSE;
               next_erase_q = nvm_ctrl[mpcm_pkg::NVM_ROW_ERASE_BIT];
               next_write_q = !nvm_ctrl[mpcm_pkg::NVM_ROW_ERASE_BIT];
               next_mask_q = multi ? 8'hFF :
                  8'(8'h01 << tbl_ptr[mpcm_pkg::PANEL_LSB +: 3]);
               next_offset_q = nvm_ctrl[mpcm_pkg::NVM_ROW_ERASE_BIT] ?
                  {3'h0, tbl_ptr[12:mpcm_pkg::ROW_LSB]} :
                  tbl_ptr[12:mpcm_pkg::CHUNK_LSB];
            end
         end
         mpcm_pkg::MPCM_PULSE: begin
            // Words arriving during the pulse are dropped
            if (!sclk_sync[1]) begin
               next_state = mpcm_pkg::MPCM_IDLE;
               next_erase_q = 1'b0;
               next_write_q = 1'b0;
            end
         end
         default: begin
            next_state = mpcm_pkg::MPCM_IDLE;
            next_erase_q = 1'b0;
            next_write_q = 1'b0;
         end
      endcase
   end

   // System domain registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= mpcm_pkg::MPCM_IDLE;
         working <= 8'h00;
         tbl_ptr <= mpcm_pkg::ADDR_RESET;
         nvm_ctrl <= mpcm_pkg::NVM_CONTROL_RESET;
         prog_ctrl <= mpcm_pkg::PROGRAMMING_CONTROL_RESET;
         erase_q <= 1'b0;
         write_q <= 1'b0;
         mask_q <= 8'h00;
         offset_q <= 10'h000;
      end else if (ce_i) begin
         state <= next_state;
         working <= next_working;
         tbl_ptr <= next_tbl_ptr;
         nvm_ctrl <= next_nvm_ctrl;
         prog_ctrl <= next_prog_ctrl;
         erase_q <= next_erase_q;
         write_q <= next_write_q;
         mask_q <= next_mask_q;
         offset_q <= next_offset_q;
      end
   end

   // Panel write buffers
   mpcm_buffer_mem u_buf (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .wr_en_i(mem_we),
      .wr_idx_i(mem_idx),
      .wr_data_i({op_hi, op_lo}),
      .rd_idx_i(array_rd_idx_i),
      .rd_data_o(array_rd_data_o)
   );

   // Output drive; data line is never driven by this block
   assign prog_serial_line_o = 1'b0;
   assign prog_serial_line_oe_o = 1'b0;
   assign array_erase_o = erase_q;
   assign array_write_o = write_q;
   assign array_panel_mask_o = mask_q;
   assign array_offset_o = offset_q;
   assign table_address_pointer_o = tbl_ptr;
   assign programming_control_o = prog_ctrl;
   assign nvm_control_reg_o = nvm_ctrl;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence take_s(logic [3:0] c);
      word_take && state == mpcm_pkg::MPCM_IDLE && cmd == c;
   endsequence

   ptr_step_two_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      take_s(mpcm_pkg::CMD_TWR_INC2) |=> tbl_ptr == $past(tbl_ptr) + 22'h00_0002)
      else $error("pointer did not advance by two");
   ptr_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      take_s(mpcm_pkg::CMD_TWR) |=> $stable(tbl_ptr))
      else $error("plain table write moved pointer");
   ctrl_setup_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      take_s(mpcm_pkg::CMD_TWR) ##0 (nvm_ctrl[mpcm_pkg::NVM_CFG_SEL_BIT] &&
      tbl_ptr == mpcm_pkg::PROGRAMMING_CONTROL_ADDR) |=> prog_ctrl == $past(op_lo))
      else $error("programming control not written");
   pulse_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(array_erase_o) || $rose(array_write_o) |-> $past(win_sync[1]) && $past(sclk_sync[1]))
      else $error("pulse began outside the held fourth clock");
   pulse_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && state == mpcm_pkg::MPCM_PULSE && !sclk_sync[1] |=> !array_erase_o && !array_write_o)
      else $error("pulse outlived the falling clock");
   erase_all_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(array_erase_o) && $past(multi) |-> array_panel_mask_o == 8'hFF)
      else $error("multi-panel erase missed a panel");
   row_offset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(array_erase_o) |-> array_offset_o == {3'h0, tbl_ptr[12:6]})
      else $error("erase row offset differs from pointer");
   write_all_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(array_write_o) && $past(multi) |-> array_panel_mask_o == 8'hFF ##0
      array_offset_o == tbl_ptr[12:3])
      else $error("multi-panel write mask or offset wrong");
   busy_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      word_take && state == mpcm_pkg::MPCM_PULSE |=> $stable(tbl_ptr) && !$past(mem_we))
      else $error("word acted on during pulse");
   buffer_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      take_s(mpcm_pkg::CMD_TWR_START) ##0 !nvm_ctrl[mpcm_pkg::NVM_CFG_SEL_BIT] |-> mem_we)
      else $error("start command did not store its bytes");
endmodule
`default_nettype wire

// file: sim/mpcm_prog_model.sv
// Programmer model that drives the serial programming clock and data line.
// Assumes the device samples data on the falling clock edge, LSB first.
`timescale 1ns/100ps
`default_nettype none
module mpcm_prog_model #(
   parameter real HALF_NS = 62.5,
   parameter int GAP_NS = 250,
   parameter int DISCHARGE_NS = 500
) (
   // Serial link toward the device
   output logic prog_serial_clock_o,
   output logic prog_serial_line_o
);
   // ---------------------------------------------------------------
   // Idle levels: clock low outside frames
   // ---------------------------------------------------------------
   initial begin
      prog_serial_clock_o = 1'b0;
      prog_serial_line_o = 1'b0;
   end

   // Shift a slice of a frame, data changed with the rising edge
   task automatic shift_bits(input logic [19:0] w, input int first, input int last);
      for (int i = first; i <= last; i++) begin
         #(HALF_NS) prog_serial_clock_o = 1'b1;
         prog_serial_line_o = w[i];
         #(HALF_NS) prog_serial_clock_o = 1'b0;
      end
   endtask

   // Undriven line shows the inverse of its last value, then a gap
   task automatic frame_gap(input logic last_bit);
      #(HALF_NS) prog_serial_line_o = ~last_bit;
      #(GAP_NS);
   endtask

   // Whole instruction: command then operand, 20 falling edges
   task automatic send_instr(input logic [3:0] cmd, input logic [15:0] opnd);
      shift_bits({opnd, cmd}, 0, 19);
      frame_gap(opnd[15]);
   endtask

   // No-op with its fourth clock left high to time the pulse
   task automatic pulse_begin();
      shift_bits(20'h0_0000, 0, 2);
      #(HALF_NS) prog_serial_clock_o = 1'b1;
      prog_serial_line_o = 1'b0;
   endtask

   // Falling clock ends the pulse; low held for discharge
   task automatic pulse_end();
      prog_serial_clock_o = 1'b0;
      #(DISCHARGE_NS);
      shift_bits(20'h0_0000, 4, 19);
      frame_gap(1'b0);
   endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the multi-panel erase and write sequencer.
// Assumes the programmer model of this folder drives the serial link.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic clk_i, rst_n_i, ce_i, prog_clk, prog_dat, line_o, line_oe, erase, write;
   logic [4:0] rd_idx;
   logic [7:0] mask, pctl, nvm;
   logic [9:0] ofs;
   logic [15:0] rd_data;
   logic [21:0] ptr;
   int num_errors = 0;
   int samples_checked = 0;

   // ---------------------------------------------------------------
   // Device and programmer
   // ---------------------------------------------------------------
   mpcm_sequencer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .prog_serial_clock_i(prog_clk), .prog_serial_line_i(prog_dat),
      .prog_serial_line_o(line_o), .prog_serial_line_oe_o(line_oe),
      .array_erase_o(erase), .array_write_o(write), .array_panel_mask_o(mask),
      .array_offset_o(ofs), .array_rd_idx_i(rd_idx), .array_rd_data_o(rd_data),
      .table_address_pointer_o(ptr), .programming_control_o(pctl),
      .nvm_control_reg_o(nvm));
   mpcm_prog_model u_prog (.prog_serial_clock_o(prog_clk), .prog_serial_line_o(prog_dat));

   // 40 MHz system clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [21:0] got, input logic [21:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Load the pointer with literal-then-store pairs
   task automatic set_ptr(input logic [21:0] a);
      u_prog.send_instr(4'h0, {8'h0E, 2'b00, a[21:16]});
      u_prog.send_instr(4'h0, 16'h6EF8);
      u_prog.send_instr(4'h0, {8'h0E, a[15:8]});
      u_prog.send_instr(4'h0, 16'h6EF7);
      u_prog.send_instr(4'h0, {8'h0E, a[7:0]});
      u_prog.send_instr(4'h0, 16'h6EF6);
   endtask

   // Timed pulse: level, panels and offset while held, idle after fall
   task automatic run_pulse(input logic er, input logic wr, input logic [7:0] m,
                            input logic [9:0] o);
      u_prog.pulse_begin();
      #400;
      check(22'({erase, write}), 22'({er, wr}), "pulse kind");
      if (er || wr) begin
         check(22'(mask), 22'(m), "panel mask");
         check(22'(ofs), 22'(o), "panel offset");
      end
      u_prog.pulse_end();
      check(22'({erase, write}), 22'h00_0000, "pulse ended");
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      rd_idx = 5'h00;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      check(ptr, 22'h00_0000, "pointer reset");
      check(22'({pctl, nvm}), 22'h00_0000, "control reset");
      check(22'({line_o, line_oe, erase, write}), 22'h00_0000, "outputs idle");
      $display("test reset done");
      // Setup of multi-panel mode through config space
      u_prog.send_instr(4'h0, 16'h8EA6);
      u_prog.send_instr(4'h0, 16'h8CA6);
      u_prog.send_instr(4'h0, 16'h84A6);
      check(22'(nvm), 22'h00_00C4, "control bits set");
      set_ptr(22'h3C_0006);
      check(ptr, 22'h3C_0006, "pointer fields");
      u_prog.send_instr(4'hC, 16'h0040);
      check(22'(pctl), 22'h00_0040, "multi-panel enable");
      check(ptr, 22'h3C_0006, "plain write keeps pointer");
      u_prog.send_instr(4'h0, 16'h8EA6);
      u_prog.send_instr(4'h0, 16'h9CA6);
      check(22'(nvm), 22'h00_0084, "config select cleared");
      $display("test setup done");
      // Two neighbouring rows erased in all panels
      for (int r = 3; r < 5; r++) begin
         set_ptr(22'(r * 64));
         u_prog.send_instr(4'h0, 16'h88A6);
         u_prog.send_instr(4'hF, 16'h0000);
         run_pulse(1'b1, 1'b0, 8'hFF, 10'(r));
      end
      $display("test erase done");
      // Load all eight buffers, last load starts programming
      u_prog.send_instr(4'h0, 16'h98A6);
      for (int p = 0; p < 8; p++) begin
         set_ptr({6'h00, 3'(p), 13'h0008});
         for (int k = 0; k < 4; k++) begin
            u_prog.send_instr((k < 3) ? 4'hD : ((p == 7) ? 4'hF : 4'hC),
               {8'(p) ^ 8'hA5, 8'(k) ^ 8'h3C});
         end
         check(ptr, {6'h00, 3'(p), 13'h000E}, "pointer after loads");
      end
      run_pulse(1'b0, 1'b1, 8'hFF, 10'h001);
      for (int p = 0; p < 8; p++) begin
         for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            rd_idx <= {3'(p), 2'(k)};
            repeat (2) @(posedge clk_i);
            check(22'(rd_data), 22'({8'(p) ^ 8'hA5, 8'(k) ^ 8'h3C}), "buffer word");
         end
      end
      $display("test write done");
      // Without write-allow no pulse may start
      u_prog.send_instr(4'h0, 16'h94A6);
      check(22'(nvm), 22'h00_0080, "write allow cleared");
      u_prog.send_instr(4'hF, 16'h0000);
      run_pulse(1'b0, 1'b0, 8'hFF, 10'h000);
      $display("test refusal done");
      // Enable low freezes the word; it acts once enable returns
      @(posedge clk_i);
      ce_i <= 1'b0;
      u_prog.send_instr(4'hD, 16'h1234);
      check(ptr, 22'h00_E00E, "pointer frozen");
      @(posedge clk_i);
      ce_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      check(ptr, 22'h00_E010, "pointer resumed");
      u_prog.send_instr(4'h0, 16'h6AF7);
      check(ptr, 22'h00_0010, "high byte cleared");
      $display("test enable done");
      // Single-panel erase selects only the pointer's panel
      u_prog.send_instr(4'h0, 16'h8CA6);
      set_ptr(22'h3C_0006);
      u_prog.send_instr(4'hC, 16'h0000);
      check(22'(pctl), 22'h00_0000, "single-panel select");
      u_prog.send_instr(4'h0, 16'h9CA6);
      u_prog.send_instr(4'h0, 16'h84A6);
      u_prog.send_instr(4'h0, 16'h88A6);
      set_ptr(22'h00_A080);
      u_prog.send_instr(4'hF, 16'h0000);
      run_pulse(1'b1, 1'b0, 8'h20, 10'h002);
      $display("test single panel done");
      final_report();
   end

   // Watchdog against a hung link
   initial begin
      #2000000;
      num_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      final_report();
   end
endmodule
`default_nettype wire
